//--- src/incr_or_pkg.sv
// Shared types and constants for the increment-and-skip / literal-OR execution block.
// Assumes one 10 MHz clock where every clock cycle is one instruction phase.
package incr_or_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned PHASES_PER_CYCLE = 4;

  // ----------------------------------------------------------------
  // Opcode fields
  // ----------------------------------------------------------------
  localparam logic [5:0] OP_SKIP_ZERO    = 6'h0F;
  localparam logic [5:0] OP_SKIP_NONZERO = 6'h12;
  localparam logic [7:0] OP_OR_LITERAL   = 8'h09;
  localparam int unsigned OPC_HI = 15;
  localparam int unsigned OPC6_LO = 10;
  localparam int unsigned OPC8_LO = 8;
  localparam int unsigned DEST_BIT = 9;
  localparam int unsigned ACCESS_BIT = 8;

  // ----------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] INDEX_LIMIT  = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  ACC_RESET   = 8'h00;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  localparam logic [7:0]  BYTE_ONE    = 8'h01;
  localparam logic [11:0] ADDR_RESET  = 12'h000;
  localparam logic [1:0]  SKIP_NONE   = 2'h0;
  localparam logic [1:0]  SKIP_ONE    = 2'h1;
  localparam logic [1:0]  SKIP_TWO    = 2'h2;

  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_e;

  typedef enum logic [1:0] {
    K_NONE     = 2'b00,
    K_SKIP_Z   = 2'b01,
    K_SKIP_NZ  = 2'b10,
    K_OR_LIT   = 2'b11
  } kind_e;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

  typedef struct packed {
    phase_e phase;
  } seq_state_s;

  typedef struct packed {
    kind_e      kind;
    logic       dest_file;
    logic       bank_used;
    logic       indexed;
    logic [7:0] operand;
    logic [7:0] result;
    logic [1:0] skip_cnt;
    logic [7:0] acc;
    logic       flag_n;
    logic       flag_z;
    mem_req_s   mem;
  } core_state_s;

  localparam mem_req_s MEM_IDLE = '{rd: 1'b0, wr: 1'b0, addr: ADDR_RESET, wdata: BYTE_ZERO};

  localparam core_state_s CORE_RESET = '{
    kind: K_NONE, dest_file: 1'b0, bank_used: 1'b0, indexed: 1'b0,
    operand: BYTE_ZERO, result: BYTE_ZERO, skip_cnt: SKIP_NONE,
    acc: ACC_RESET, flag_n: 1'b0, flag_z: 1'b0, mem: MEM_IDLE};

endpackage : incr_or_pkg

//--- src/q_phase_sequencer.sv
// Four-phase instruction cycle sequencer: one clock cycle per phase.
// Assumes synchronous active-low reset; Q1 is the first phase after release.
`timescale 1ns/1ps
module q_phase_sequencer
  import incr_or_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   rstn,
  output phase_e      phase
);

  seq_state_s cur;
  seq_state_s next_state;

  always_comb
  begin
    next_state = cur;
    unique case (cur.phase)
      PH_Q1: next_state.phase = PH_Q2;
      PH_Q2: next_state.phase = PH_Q3;
      PH_Q3: next_state.phase = PH_Q4;
      PH_Q4: next_state.phase = PH_Q1;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      cur <= '{phase: PH_Q1};
    else
      cur <= next_state;
  end

  assign phase = cur.phase;

endmodule : q_phase_sequencer

//--- src/incr_skip_or_literal_exec.sv
// Execution of increment-and-skip (zero / nonzero) and literal OR into the accumulator.
// Assumes the fetch unit presents the instruction during Q1 and the data memory
// answers a read combinationally in the same Q2 cycle.
//
// Overview of operation
// - Pattern 001111da: increment, skip when zero
// - Pattern 010010da: increment, skip when nonzero
// - Nonzero variant discards next on nonzero result
// - Destination bit: clear accumulator, set file
// - Access bit clear shared page, set bank
// - Extended set, access clear, f<=5F indexed
// - Taken skip adds one no-operation cycle
// - Two-word skipped instruction adds two cycles
// - Increment-and-skip never touches status flags
// - 00001001 literal ORed into accumulator, flags N Z
// - Literal OR completes in one cycle
`timescale 1ns/1ps
module incr_skip_or_literal_exec
  import incr_or_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr,
  input  wire logic        next_two_word,
  input  wire logic        ext_set_en,
  input  wire logic [3:0]  bank_pointer_register,
  input  wire logic [11:0] index_base,
  input  wire logic [7:0]  mem_rdata,
  output mem_req_s         mem_req,
  output logic [7:0]       accumulator,
  output logic             flag_negative,
  output logic             flag_zero,
  output logic             nop_cycle,
  output logic             executing,
  output phase_e           phase
);

  // ----------------------------------------------------------------
  // Phase sequencing
  // ----------------------------------------------------------------
  q_phase_sequencer u_seq (
    .clk   (clk),
    .rstn  (rstn),
    .phase (phase)
  );

  core_state_s cur;
  core_state_s next_state;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic       is_skip_z;
  logic       is_skip_nz;
  logic       is_or_lit;
  logic       use_index;
  logic [7:0] faddr;
  logic [7:0] incremented;
  logic       file_op;

  assign faddr      = instr[7:0];
  assign is_skip_z  = instr[OPC_HI:OPC6_LO] == OP_SKIP_ZERO;
  assign is_skip_nz = instr[OPC_HI:OPC6_LO] == OP_SKIP_NONZERO;
  assign is_or_lit  = instr[OPC_HI:OPC8_LO] == OP_OR_LITERAL;
  assign use_index  = ext_set_en && !instr[ACCESS_BIT] && (faddr <= INDEX_LIMIT);
  // Eight-bit sum drops the carry on purpose
  assign incremented = cur.operand + BYTE_ONE;
  assign file_op    = (cur.kind == K_SKIP_Z) || (cur.kind == K_SKIP_NZ);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = cur;
    unique case (phase)
      PH_Q1:
      begin
        // A pending skip swallows this cycle whole, whatever the fetch offers
        if (cur.skip_cnt == SKIP_NONE && instr_valid)
        begin
          if (is_skip_z || is_skip_nz)
          begin
            next_state.kind      = is_skip_z ? K_SKIP_Z : K_SKIP_NZ;
            next_state.dest_file = instr[DEST_BIT];
            next_state.bank_used = instr[ACCESS_BIT];
            next_state.indexed   = use_index;
            next_state.mem.rd    = 1'b1;
            if (use_index)
              next_state.mem.addr = index_base + {4'h0, faddr};
            else if (instr[ACCESS_BIT])
              next_state.mem.addr = {bank_pointer_register, faddr};
            else if (faddr < ACCESS_SPLIT)
              next_state.mem.addr = {ACCESS_LOW_BANK, faddr};
            else
              next_state.mem.addr = {ACCESS_HIGH_BANK, faddr};
          end
          else if (is_or_lit)
          begin
            next_state.kind      = K_OR_LIT;
            next_state.dest_file = 1'b0;
            next_state.indexed   = 1'b0;
          end
        end
      end
      PH_Q2:
      begin
        next_state.mem.rd = 1'b0;
        if (file_op)
          next_state.operand = mem_rdata;
        else if (cur.kind == K_OR_LIT)
          next_state.operand = instr[7:0];
      end
      PH_Q3:
      begin
        if (cur.kind == K_OR_LIT)
          next_state.result = cur.acc | cur.operand;
        else if (file_op)
        begin
          next_state.result = incremented;
          if (cur.dest_file)
          begin
            next_state.mem.wr    = 1'b1;
            next_state.mem.wdata = incremented;
          end
        end
      end
      PH_Q4:
      begin
        next_state.mem.wr = 1'b0;
        next_state.kind   = K_NONE;
        if (cur.kind == K_OR_LIT)
        begin
          next_state.acc    = cur.result;
          next_state.flag_n = cur.result[7];
          next_state.flag_z = cur.result == BYTE_ZERO;
        end
        else if (file_op)
        begin
          // Flags are left alone here by design
          if (!cur.dest_file)
            next_state.acc = cur.result;
          if ((cur.kind == K_SKIP_Z && cur.result == BYTE_ZERO) ||
              (cur.kind == K_SKIP_NZ && cur.result != BYTE_ZERO))
            next_state.skip_cnt = next_two_word ? SKIP_TWO : SKIP_ONE;
        end
        else if (cur.skip_cnt != SKIP_NONE)
          next_state.skip_cnt = cur.skip_cnt - SKIP_ONE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      cur <= CORE_RESET;
    else
      cur <= next_state;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_req       = cur.mem;
  assign accumulator   = cur.acc;
  assign flag_negative = cur.flag_n;
  assign flag_zero     = cur.flag_z;
  assign nop_cycle     = cur.skip_cnt != SKIP_NONE;
  assign executing     = cur.kind != K_NONE;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence skip_decided;
    phase == PH_Q4 && file_op &&
      ((cur.kind == K_SKIP_Z && cur.result == BYTE_ZERO) ||
       (cur.kind == K_SKIP_NZ && cur.result != BYTE_ZERO));
  endsequence

  sequence nop_one_cycle;
    nop_cycle [*4] ##1 !nop_cycle;
  endsequence

  sequence nop_two_cycles;
    nop_cycle [*8] ##1 !nop_cycle;
  endsequence

  a_zero_skip_taken: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q4 && cur.kind == K_SKIP_Z && cur.result == BYTE_ZERO |=> nop_cycle)
    else $error("zero result did not skip");

  a_nonzero_skip_rule: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q4 && cur.kind == K_SKIP_NZ |=> nop_cycle == ($past(cur.result) != BYTE_ZERO))
    else $error("nonzero skip decision wrong");

  a_dest_file_write: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q3 && file_op && cur.dest_file |=>
      mem_req.wr && mem_req.wdata == cur.result ##1 !mem_req.wr)
    else $error("file destination not written");

  a_dest_acc_load: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q4 && file_op && !cur.dest_file |=> accumulator == $past(cur.result) && !mem_req.wr)
    else $error("accumulator destination not loaded");

  a_bank_addr_used: assert property (@(posedge clk) disable iff (!rstn)
    mem_req.rd && cur.bank_used && !cur.indexed |-> mem_req.addr[11:8] == $past(bank_pointer_register))
    else $error("bank pointer not used");

  a_index_mode_sel: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q1 && cur.skip_cnt == SKIP_NONE && instr_valid && (is_skip_z || is_skip_nz) |=>
      cur.indexed == $past(use_index))
    else $error("indexed mode selection wrong");

  a_skip_one_nop: assert property (@(posedge clk) disable iff (!rstn)
    skip_decided and (!next_two_word) |=> nop_one_cycle)
    else $error("single skip length wrong");

  a_skip_two_nop: assert property (@(posedge clk) disable iff (!rstn)
    skip_decided and next_two_word |=> nop_two_cycles)
    else $error("two-word skip length wrong");

  a_flags_held: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q4 && file_op |=> $stable(flag_negative) && $stable(flag_zero))
    else $error("increment-and-skip touched flags");

  a_phase_slots: assert property (@(posedge clk) disable iff (!rstn)
    (mem_req.rd |-> phase == PH_Q2) and (mem_req.wr |-> phase == PH_Q4))
    else $error("memory access in wrong phase");

  a_or_literal: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q1 && cur.skip_cnt == SKIP_NONE && instr_valid && is_or_lit |=>
      ##3 accumulator == ($past(accumulator, 3) | $past(instr[7:0], 3)) &&
      flag_zero == (accumulator == BYTE_ZERO) && flag_negative == accumulator[7])
    else $error("literal OR result or flags wrong");

  a_incr_wrap: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q3 && file_op && cur.operand == 8'hFF |=> cur.result == BYTE_ZERO)
    else $error("increment did not wrap");

  // ----------------------------------------------------------------
  // Slot, addressing and refusal checks
  // ----------------------------------------------------------------
  // An instruction counts as taken only at the end of a free Q1
  logic taken;
  assign taken = phase == PH_Q1 && cur.skip_cnt == SKIP_NONE && instr_valid &&
                 (is_skip_z || is_skip_nz || is_or_lit);

  sequence exec_span;
    executing [*3] ##1 !executing;
  endsequence

  sequence read_slot;
    mem_req.rd && phase == PH_Q2 ##1 !mem_req.rd;
  endsequence

  a_exec_window: assert property (@(posedge clk) disable iff (!rstn)
    taken |=> exec_span)
    else $error("instruction did not occupy Q2 to Q4");

  a_read_slot: assert property (@(posedge clk) disable iff (!rstn)
    taken && !is_or_lit |=> read_slot)
    else $error("file read not confined to Q2");

  a_or_no_memory: assert property (@(posedge clk) disable iff (!rstn)
    executing && cur.kind == K_OR_LIT |-> !mem_req.rd && !mem_req.wr)
    else $error("literal OR touched file memory");

  // The fetch may keep offering words while a skip runs; none may start
  a_nop_refuses: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q1 && nop_cycle && instr_valid |=> !executing && cur.kind == K_NONE)
    else $error("instruction accepted during skipped cycle");

  a_nop_quiet: assert property (@(posedge clk) disable iff (!rstn)
    nop_cycle |-> !executing && !mem_req.rd && !mem_req.wr)
    else $error("activity during skipped cycle");

  a_zero_no_skip: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q4 && cur.kind == K_SKIP_Z && cur.result != BYTE_ZERO |=> !nop_cycle)
    else $error("nonzero result skipped");

  a_acc_kept_file: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q4 && file_op && cur.dest_file |=> $stable(accumulator))
    else $error("file destination changed accumulator");

  a_acc_dest_silent: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q3 && file_op && !cur.dest_file |=> !mem_req.wr)
    else $error("accumulator destination wrote file");

  a_access_page: assert property (@(posedge clk) disable iff (!rstn)
    mem_req.rd && !cur.bank_used && !cur.indexed |->
      mem_req.addr[11:8] == (mem_req.addr[7:0] < ACCESS_SPLIT ?
                             ACCESS_LOW_BANK : ACCESS_HIGH_BANK))
    else $error("shared page address wrong");

  a_index_address: assert property (@(posedge clk) disable iff (!rstn)
    mem_req.rd && cur.indexed |->
      mem_req.addr == $past(index_base) + {4'h0, $past(instr[7:0])})
    else $error("indexed address wrong");

  a_operand_capture: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q2 && file_op |=> cur.operand == $past(mem_rdata))
    else $error("file operand not taken in Q2");

  a_literal_capture: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q2 && cur.kind == K_OR_LIT |=> cur.operand == $past(instr[7:0]))
    else $error("literal not taken in Q2");

  a_or_flag_source: assert property (@(posedge clk) disable iff (!rstn)
    phase == PH_Q4 && cur.kind == K_OR_LIT |=>
      flag_zero == ($past(cur.result) == BYTE_ZERO) && flag_negative == $past(cur.result[7]))
    else $error("literal OR flags wrong");

endmodule : incr_skip_or_literal_exec

//--- bench/file_memory_model.sv
// Banked file memory that answers the execution block's data requests.
// Assumes a read is answered combinationally while rd is high in Q2.
`timescale 1ns/1ps
module file_memory_model
  import incr_or_pkg::*;
(
  input  wire logic       clk,
  input  wire mem_req_s   mem_req,
  output logic [7:0]      mem_rdata
);
  // ----------------------------------------------------------------
  // Storage and read path
  // ----------------------------------------------------------------
  logic [7:0] mem [0:4095];
  logic [7:0] last = 8'h00;

  // Outside a read the bus flips every cycle, so a late sample cannot pass
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~last;

  always @(posedge clk)
  begin
    if (mem_req.rd)
      last <= mem[mem_req.addr];
    else
      last <= ~last;
    if (mem_req.wr)
      mem[mem_req.addr] <= mem_req.wdata;
  end
endmodule : file_memory_model

//--- bench/tb_top.sv
// Self-checking bench for the increment-and-skip and literal-OR block.
// Assumes the file memory model stands on the data side.
`timescale 1ns/1ps
module tb_top
  import incr_or_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn;
  logic        instr_valid;
  logic [15:0] instr;
  logic        next_two_word;
  logic        ext_set_en;
  logic [3:0]  bank_pointer_register;
  logic [11:0] index_base;
  logic [7:0]  mem_rdata;
  mem_req_s    mem_req;
  logic [7:0]  accumulator;
  logic        flag_negative;
  logic        flag_zero;
  logic        nop_cycle;
  logic        executing;
  phase_e      phase;
  int          failures;
  int          compares;
  int          nops;
  logic        exe_q2;
  logic        rd_q2;
  logic        wr_q4;
  logic [11:0] addr_q2;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  incr_skip_or_literal_exec uut (.clk(clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr(instr), .next_two_word(next_two_word), .ext_set_en(ext_set_en),
    .bank_pointer_register(bank_pointer_register), .index_base(index_base),
    .mem_rdata(mem_rdata), .mem_req(mem_req), .accumulator(accumulator),
    .flag_negative(flag_negative), .flag_zero(flag_zero), .nop_cycle(nop_cycle),
    .executing(executing), .phase(phase));

  file_memory_model mem_model (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Offers one instruction in Q1, records Q2/Q4 activity, then counts skipped cycles;
  // a decoy OR offered in the first skipped Q1 must be refused
  task automatic issue(input logic [15:0] word, input logic two, input logic ext,
                       input logic [3:0] bank, input logic [11:0] base, input logic decoy);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (phase !== PH_Q4 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("phase", 12'h003, {10'h000, phase});
    @(posedge clk);
    instr <= word;
    instr_valid <= 1'b1;
    next_two_word <= two;
    ext_set_en <= ext;
    bank_pointer_register <= bank;
    index_base <= base;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
    exe_q2 = executing;
    rd_q2 = mem_req.rd;
    addr_q2 = mem_req.addr;
    repeat (2) @(posedge clk);
    #1;
    wr_q4 = mem_req.wr;
    @(posedge clk);
    instr <= 16'h09FF;
    instr_valid <= decoy;
    #1;
    nops = 0;
    while (nop_cycle === 1'b1 && nops < 20)
    begin
      @(posedge clk);
      instr_valid <= 1'b0;
      #1;
      nops++;
    end
  endtask : issue

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_or_zero;
    issue(16'h0900, 1'b0, 1'b0, 4'h0, 12'h000, 1'b0);
    chk("exe_q2", 12'h001, {11'h000, exe_q2});
    chk("acc", 12'h000, {4'h0, accumulator});
    chk("flag_z", 12'h001, {11'h000, flag_zero});
    chk("flag_n", 12'h000, {11'h000, flag_negative});
    chk("nops", 12'h000, 12'(nops));
    $display("test or_zero done");
  endtask : t_or_zero

  task automatic t_nonzero_skip_two;
    mem_model.mem[12'hF90] = 8'h99;
    issue(16'h4890, 1'b1, 1'b0, 4'h5, 12'h000, 1'b1);
    chk("addr", 12'hF90, addr_q2);
    chk("acc", 12'h09A, {4'h0, accumulator});
    chk("wr_q4", 12'h000, {11'h000, wr_q4});
    chk("nops", 12'h008, 12'(nops));
    chk("flag_z", 12'h001, {11'h000, flag_zero});
    $display("test nonzero_skip_two done");
  endtask : t_nonzero_skip_two

  task automatic t_or_literal;
    issue(16'h0935, 1'b0, 1'b0, 4'h0, 12'h000, 1'b0);
    chk("acc", 12'h0BF, {4'h0, accumulator});
    chk("flags", 12'h002, {10'h000, flag_negative, flag_zero});
    $display("test or_literal done");
  endtask : t_or_literal

  task automatic t_zero_skip_wrap;
    mem_model.mem[12'h310] = 8'hFF;
    issue(16'h3F10, 1'b0, 1'b0, 4'h3, 12'h000, 1'b1);
    chk("rd_q2", 12'h001, {11'h000, rd_q2});
    chk("addr", 12'h310, addr_q2);
    chk("wr_q4", 12'h001, {11'h000, wr_q4});
    chk("file", 12'h000, {4'h0, mem_model.mem[12'h310]});
    chk("nops", 12'h004, 12'(nops));
    chk("acc", 12'h0BF, {4'h0, accumulator});
    chk("flags", 12'h002, {10'h000, flag_negative, flag_zero});
    $display("test zero_skip_wrap done");
  endtask : t_zero_skip_wrap

  task automatic t_nonzero_indexed;
    mem_model.mem[12'h120] = 8'hFF;
    issue(16'h4A20, 1'b0, 1'b1, 4'h7, 12'h100, 1'b0);
    chk("addr", 12'h120, addr_q2);
    chk("file", 12'h000, {4'h0, mem_model.mem[12'h120]});
    chk("nops", 12'h000, 12'(nops));
    $display("test nonzero_indexed done");
  endtask : t_nonzero_indexed

  task automatic t_zero_noskip;
    mem_model.mem[12'h060] = 8'h41;
    issue(16'h3C60, 1'b1, 1'b1, 4'h7, 12'h100, 1'b0);
    chk("addr", 12'h060, addr_q2);
    chk("acc", 12'h042, {4'h0, accumulator});
    chk("nops", 12'h000, 12'(nops));
    $display("test zero_noskip done");
  endtask : t_zero_noskip

  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    failures = 0;
    compares = 0;
    rstn = 1'b0;
    instr_valid = 1'b0;
    instr = 16'h0000;
    next_two_word = 1'b0;
    ext_set_en = 1'b0;
    bank_pointer_register = 4'h0;
    index_base = 12'h000;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_or_zero();
    t_nonzero_skip_two();
    t_or_literal();
    t_zero_skip_wrap();
    t_nonzero_indexed();
    t_zero_noskip();
    conclude();
  end

  // The tests need about 70 cycles; 10000 leaves room without hiding a hang
  initial
  begin
    #(10000 * CLK_PERIOD_NS);
    failures++;
    $display("watchdog expired");
    conclude();
  end
endmodule : tb_top
